// ### dma_cc_pkg.sv
// Contract
// - Normal mode stops on count underflow
// - Normal completion clears the enable bit
// - Completion raises interrupt unless channel masked
// - Ring mode ignores count, runs until disabled
// - Ring mode never raises completion interrupt
// - Fixed address stays at programmed value
// - Incrementing 8-bit address ends last plus one
// - Incrementing 16-bit address ends last plus two
// - Count reads all ones after completion
// - Count writes ignored while channel enabled
// - Request flag cleared by writing zero or by a finished unit
// - Cross-channel DMA address writes always accepted
// - Status bit written one keeps its value
// - Count decrements once per unit, 256 maximum

// ****************************************
// Shared constants of the completion block
// ****************************************
package dma_cc_pkg;

  // Number of channels and widths
  localparam int NCH_DEF = 10;
  localparam int ADDR_W = 32;
  localparam int CNT_W = 8;
  localparam int BUS_AW = 8;
  localparam int BUS_DW = 32;

  // Per-channel word offsets, channel n at n times the stride
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_SRC = 8'h04;
  localparam logic [7:0] OFF_DST = 8'h08;
  localparam logic [7:0] OFF_CNT = 8'h0C;
  localparam logic [7:0] CH_STRIDE = 8'h10;

  // Shared registers above the channel windows
  localparam logic [7:0] OFF_STAT = 8'hF0;
  localparam logic [7:0] OFF_MASK = 8'hF4;

  // Control register field positions
  localparam int CTL_EN = 0;
  localparam int CTL_REQ = 1;
  localparam int CTL_RING = 2;
  localparam int CTL_SZ16 = 3;
  localparam int CTL_SINC = 4;
  localparam int CTL_DINC = 5;

  // Reset values
  localparam logic [ADDR_W-1:0] ADDR_RST = 32'h00000000;
  localparam logic [CNT_W-1:0] CNT_RST = 8'h00;
  localparam logic [BUS_DW-1:0] MASK_RST = 32'h00000000;

  // Count arithmetic
  localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
  localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
  localparam logic [CNT_W-1:0] CNT_ONES = 8'hFF;

  // Address steps and ring wrap masks
  localparam logic [ADDR_W-1:0] STEP8 = 32'h00000001;
  localparam logic [ADDR_W-1:0] STEP16 = 32'h00000002;
  localparam logic [ADDR_W-1:0] RING8_MASK = 32'h0000001F;
  localparam logic [ADDR_W-1:0] RING16_MASK = 32'h0000003F;

endpackage

// ### dma_addr_step.sv
`timescale 1ns/10ps
// ****************************************
// Next address after one transfer unit
// ****************************************
module dma_addr_step
(
  // Current state
  input wire logic [dma_cc_pkg::ADDR_W-1:0] addrIn,
  // Mode
  input wire logic incEn,
  input wire logic size16,
  input wire logic ring,
  // Result
  output logic [dma_cc_pkg::ADDR_W-1:0] addrOut
);
  import dma_cc_pkg::*;

  logic [ADDR_W-1:0] sum; // Plain increment
  logic [ADDR_W-1:0] wrapMask; // Bits that move in ring mode

  // Step by unit size, wrap low bits in ring mode
  always_comb
  begin
    sum = addrIn + (size16 ? STEP16 : STEP8);
    wrapMask = size16 ? RING16_MASK : RING8_MASK;
    if (!incEn)
    begin
      // Fixed direction: never moves
      addrOut = addrIn;
    end
    else if (ring)
    begin
      // High bits frozen so the buffer recycles to its start
      addrOut = (addrIn & ~wrapMask) | (sum & wrapMask);
    end
    else
    begin
      addrOut = sum;
    end
  end

endmodule

// ### dma_completion_ctrl.sv
// Design decisions made here: the strobed register port and the placing of the registers.
`timescale 1ns/10ps
// ****************************************
// Channel completion, interrupt and write protection
// ****************************************
module dma_completion_ctrl
#(
  parameter int NCH = dma_cc_pkg::NCH_DEF,
  parameter int CHW = $clog2(NCH)
)
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Register port
  input wire logic [dma_cc_pkg::BUS_AW-1:0] regAddr,
  input wire logic [dma_cc_pkg::BUS_DW-1:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [dma_cc_pkg::BUS_DW-1:0] regRdData,
  // Write issued by the DMA engine itself, with its channel
  input wire logic dmaWr,
  input wire logic [CHW-1:0] dmaWrCh,
  // Peripheral requests and unit completion from the engine
  input wire logic [NCH-1:0] dmaReq,
  input wire logic unitDone,
  input wire logic [CHW-1:0] unitCh,
  // Channel state
  output logic [NCH-1:0] chEn,
  output logic [NCH-1:0] chReq,
  output logic irq
);
  import dma_cc_pkg::*;

  // ****************************************
  // State
  // ****************************************
  logic [NCH-1:0] en_q, en_d; // Transfer enable
  logic [NCH-1:0] req_q, req_d; // Transfer request flag
  logic [NCH-1:0] ring_q, ring_d; // Ring buffer mode
  logic [NCH-1:0] sz_q, sz_d; // 16-bit units
  logic [NCH-1:0] sinc_q, sinc_d; // Source increments
  logic [NCH-1:0] dinc_q, dinc_d; // Destination increments
  logic [ADDR_W-1:0] src_q [NCH], src_d [NCH]; // Source address
  logic [ADDR_W-1:0] dst_q [NCH], dst_d [NCH]; // Destination address
  logic [CNT_W-1:0] cnt_q [NCH], cnt_d [NCH]; // Transfer count
  logic [NCH-1:0] stat_q, stat_d; // Sticky completion status
  logic [NCH-1:0] mask_q, mask_d; // One masks the channel
  logic [BUS_DW-1:0] rd_q, rd_d; // Read data, one cycle late

  // ****************************************
  // Helpers
  // ****************************************
  logic [ADDR_W-1:0] srcStep [NCH]; // Source after one unit
  logic [ADDR_W-1:0] dstStep [NCH]; // Destination after one unit
  logic [NCH-1:0] unitHit; // Unit finished on enabled channel
  logic [NCH-1:0] doneEv; // Normal-mode completion
  logic [NCH-1:0] wCtrl, wSrc, wDst, wCnt; // Accepted writes
  logic wStat; // Status write

  // Channel register address match
  function automatic logic hits(input logic [BUS_AW-1:0] a, input int c,
                                input logic [7:0] off);
    hits = (a == (8'(c) * CH_STRIDE + off));
  endfunction

  // Address steppers, one pair per channel
  genvar g;
  generate
    for (g = 0; g < NCH; g++)
    begin : gStep
      dma_addr_step uSrc (.addrIn(src_q[g]), .incEn(sinc_q[g]), .size16(sz_q[g]),
        .ring(ring_q[g]), .addrOut(srcStep[g]));
      dma_addr_step uDst (.addrIn(dst_q[g]), .incEn(dinc_q[g]), .size16(sz_q[g]),
        .ring(ring_q[g]), .addrOut(dstStep[g]));
    end
  endgenerate

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb
  begin
    logic cpuOk, otherOk;
    cpuOk = 1'b0;
    otherOk = 1'b0;
    en_d = en_q;
    req_d = req_q;
    ring_d = ring_q;
    sz_d = sz_q;
    sinc_d = sinc_q;
    dinc_d = dinc_q;
    mask_d = mask_q;
    stat_d = stat_q;
    for (int c = 0; c < NCH; c++)
    begin
      src_d[c] = src_q[c];
      dst_d[c] = dst_q[c];
      cnt_d[c] = cnt_q[c];
      // CPU, or another channel's DMA; own-channel DMA writes dropped
      cpuOk = regWr && !dmaWr;
      otherOk = regWr && dmaWr && (32'(dmaWrCh) != c);
      unitHit[c] = unitDone && (32'(unitCh) == c) && en_q[c];
      doneEv[c] = unitHit[c] && !ring_q[c] && (cnt_q[c] == CNT_ZERO);
      wCtrl[c] = (cpuOk || otherOk) && hits(regAddr, c, OFF_CTRL);
      // Address writes: CPU only while idle, other channels any time
      wSrc[c] = hits(regAddr, c, OFF_SRC) && ((cpuOk && !en_q[c]) || otherOk);
      wDst[c] = hits(regAddr, c, OFF_DST) && ((cpuOk && !en_q[c]) || otherOk);
      // Count is hardware protected while enabled
      wCnt[c] = hits(regAddr, c, OFF_CNT) && (cpuOk || otherOk) && !en_q[c];

      // Control write
      if (wCtrl[c])
      begin
        en_d[c] = regWrData[CTL_EN];
        // Written zero clears; written one is no-op
        if (!regWrData[CTL_REQ])
        begin
          req_d[c] = 1'b0;
        end
        // Mode bits frozen while running, avoids mid-run switch
        if (!en_q[c])
        begin
          ring_d[c] = regWrData[CTL_RING];
          sz_d[c] = regWrData[CTL_SZ16];
          sinc_d[c] = regWrData[CTL_SINC];
          dinc_d[c] = regWrData[CTL_DINC];
        end
      end
      if (wSrc[c])
      begin
        src_d[c] = regWrData;
      end
      if (wDst[c])
      begin
        dst_d[c] = regWrData;
      end
      if (wCnt[c])
      begin
        cnt_d[c] = regWrData[CNT_W-1:0];
      end

      // One unit moved
      if (unitHit[c])
      begin
        // One per unit, wraps in ring mode
        cnt_d[c] = cnt_q[c] - CNT_ONE;
        req_d[c] = 1'b0;
        // A cross-channel write in the same cycle takes priority
        if (!wSrc[c])
        begin
          src_d[c] = srcStep[c];
        end
        if (!wDst[c])
        begin
          dst_d[c] = dstStep[c];
        end
      end
      // Completion beats a same-cycle enable write
      if (doneEv[c])
      begin
        en_d[c] = 1'b0;
      end
      // New request wins over any clear
      if (dmaReq[c])
      begin
        req_d[c] = 1'b1;
      end
    end

    // Status: written zero clears, one
    wStat = regWr && (regAddr == OFF_STAT);
    if (wStat)
    begin
      stat_d = stat_q & regWrData[NCH-1:0];
    end
    // Set wins over clear; ring channels never reach doneEv
    stat_d = stat_d | doneEv;
    if (regWr && !dmaWr && (regAddr == OFF_MASK))
    begin
      mask_d = regWrData[NCH-1:0];
    end
  end

  // ****************************************
  // Read mux
  // ****************************************
  always_comb
  begin
    rd_d = '0;
    if (regRd)
    begin
      for (int c = 0; c < NCH; c++)
      begin
        if (hits(regAddr, c, OFF_CTRL))
        begin
          rd_d[CTL_EN] = en_q[c];
          rd_d[CTL_REQ] = req_q[c];
          rd_d[CTL_RING] = ring_q[c];
          rd_d[CTL_SZ16] = sz_q[c];
          rd_d[CTL_SINC] = sinc_q[c];
          rd_d[CTL_DINC] = dinc_q[c];
        end
        if (hits(regAddr, c, OFF_SRC))
        begin
          rd_d = src_q[c];
        end
        if (hits(regAddr, c, OFF_DST))
        begin
          rd_d = dst_q[c];
        end
        if (hits(regAddr, c, OFF_CNT))
        begin
          rd_d[CNT_W-1:0] = cnt_q[c];
        end
      end
      // Unmapped addresses read as zero
      if (regAddr == OFF_STAT)
      begin
        rd_d[NCH-1:0] = stat_q;
      end
      if (regAddr == OFF_MASK)
      begin
        rd_d[NCH-1:0] = mask_q;
      end
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      en_q <= '0;
      req_q <= '0;
      ring_q <= '0;
      sz_q <= '0;
      sinc_q <= '0;
      dinc_q <= '0;
      stat_q <= '0;
      mask_q <= MASK_RST[NCH-1:0];
      rd_q <= '0;
      for (int c = 0; c < NCH; c++)
      begin
        src_q[c] <= ADDR_RST;
        dst_q[c] <= ADDR_RST;
        cnt_q[c] <= CNT_RST;
      end
    end
    else
    begin
      en_q <= en_d;
      req_q <= req_d;
      ring_q <= ring_d;
      sz_q <= sz_d;
      sinc_q <= sinc_d;
      dinc_q <= dinc_d;
      stat_q <= stat_d;
      mask_q <= mask_d;
      rd_q <= rd_d;
      for (int c = 0; c < NCH; c++)
      begin
        src_q[c] <= src_d[c];
        dst_q[c] <= dst_d[c];
        cnt_q[c] <= cnt_d[c];
      end
    end
  end

  // Outputs
  assign regRdData = rd_q;
  assign chEn = en_q;
  assign chReq = req_q;
  // Level interrupt from unmasked sticky bits
  assign irq = |(stat_q & ~mask_q);

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);

  generate
    for (g = 0; g < NCH; g++)
    begin : gChk
      // Final unit of a normal run
      sequence s_lastUnit;
        unitHit[g] && !ring_q[g] && (cnt_q[g] == CNT_ZERO);
      endsequence
      // Channel closed with count at all ones
      sequence s_closed;
        !en_q[g] && (cnt_q[g] == CNT_ONES);
      endsequence

      a_run_continues: assert property (unitHit[g] && !ring_q[g] && !wCtrl[g]
        && (cnt_q[g] != CNT_ZERO) |=> en_q[g])
        else $error("normal channel stopped before underflow");
      a_done_closes: assert property (s_lastUnit
        |=> s_closed ##1 (!en_q[g] || $past(wCtrl[g])))
        else $error("completion did not disable channel");
      a_done_irq: assert property (s_lastUnit ##0 !mask_q[g] |=> stat_q[g] && irq)
        else $error("unmasked completion gave no interrupt");
      a_ring_runs: assert property (unitHit[g] && ring_q[g] && !wCtrl[g] |=> en_q[g])
        else $error("ring channel stopped by itself");
      a_ring_silent: assert property (ring_q[g] && !stat_q[g] && !doneEv[g]
        |=> !stat_q[g])
        else $error("ring channel raised completion status");
      a_fixed_addr: assert property (unitHit[g] && !sinc_q[g] && !wSrc[g]
        |=> $stable(src_q[g]))
        else $error("fixed source address moved");
      a_inc_byte: assert property (unitHit[g] && sinc_q[g] && !sz_q[g] && !ring_q[g]
        && !wSrc[g] |=> src_q[g] == $past(src_q[g]) + STEP8)
        else $error("byte source step not one");
      a_inc_half: assert property (unitHit[g] && dinc_q[g] && sz_q[g] && !ring_q[g]
        && !wDst[g] |=> dst_q[g] == $past(dst_q[g]) + STEP16)
        else $error("halfword destination step not two");
      a_cnt_guard: assert property (en_q[g] && regWr && hits(regAddr, g, OFF_CNT)
        && !unitHit[g] |=> $stable(cnt_q[g]))
        else $error("count written while enabled");
      a_req_wzero: assert property (wCtrl[g] && regWrData[CTL_REQ] && !req_q[g]
        && !dmaReq[g] |=> !req_q[g])
        else $error("request flag set by software");
      a_cross_write: assert property (regWr && dmaWr && (32'(dmaWrCh) != g)
        && hits(regAddr, g, OFF_SRC) |=> src_q[g] == $past(regWrData))
        else $error("cross-channel address write lost");
      a_stat_keep: assert property (wStat && regWrData[g] && stat_q[g] |=> stat_q[g])
        else $error("status bit written one was cleared");
      a_cnt_step: assert property (unitHit[g] && !wCnt[g]
        |=> cnt_q[g] == $past(cnt_q[g]) - CNT_ONE)
        else $error("count did not drop by one");
    end
  endgenerate

endmodule

// ### dma_engine_model.sv
`timescale 1ns/10ps
// ****************************************
// Engine side: issues transfer units
// ****************************************
module dma_engine_model
#(
  parameter int NCH = 10
)
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Bench control
  input wire logic [3:0] runCh,
  input wire logic slow,
  input wire logic load,
  input wire logic [15:0] loadCnt,
  // Block side
  input wire logic [NCH-1:0] chEn,
  output logic unitDone,
  output logic [3:0] unitCh,
  output logic idle
);
  import dma_cc_pkg::*;
  logic [15:0] left_q; // Units still to issue
  logic tick_q; // Pacing phase, slow answers every other cycle
  // Units only while enabled; it never writes its own registers
  assign unitDone = (tick_q || !slow) && (left_q != 16'h0000) && chEn[runCh];
  assign unitCh = runCh;
  assign idle = (left_q == 16'h0000);
  // Budget and pacing; gated by registered enable, so no stray unit
  always_ff @(posedge mclk)
  begin
    if (!rst_b || load)
    begin
      left_q <= load ? loadCnt : 16'h0000;
      tick_q <= 1'b0;
    end
    else
    begin
      tick_q <= !tick_q;
      if (unitDone)
      begin
        left_q <= left_q - 16'h0001;
      end
    end
  end
endmodule

// ### test_dma_completion_ctrl.sv
`timescale 1ns/10ps
// ****************************************
// Bench for the completion block
// ****************************************
module test_dma_completion_ctrl;
  import dma_cc_pkg::*;
  logic mclk, rst_b, regWr, regRd, dmaWr, unitDone, slow, load, idle; // Stimulus and taps
  logic [7:0] regAddr; // Register address
  logic [31:0] regWrData, regRdData; // Register data
  logic [3:0] dmaWrCh, unitCh, runCh; // Channel selects
  logic [9:0] dmaReq, chEn, chReq; // Per-channel lines
  logic [15:0] loadCnt; // Unit budget for the engine
  logic irqTap; // Interrupt line
  int errors = 0; // Mismatches seen
  int samples_checked = 0; // Comparisons made

  dma_completion_ctrl #(.NCH(10)) u_dma_completion_ctrl (.mclk(mclk), .rst_b(rst_b),
    .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
    .regRdData(regRdData), .dmaWr(dmaWr), .dmaWrCh(dmaWrCh), .dmaReq(dmaReq),
    .unitDone(unitDone), .unitCh(unitCh), .chEn(chEn), .chReq(chReq), .irq(irqTap));
  dma_engine_model #(.NCH(10)) u_dma_engine_model (.mclk(mclk), .rst_b(rst_b),
    .runCh(runCh), .slow(slow), .load(load), .loadCnt(loadCnt), .chEn(chEn),
    .unitDone(unitDone), .unitCh(unitCh), .idle(idle));
  // Clock, 50 ns period
  always #25 mclk = !mclk;

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic close_out;
    if (errors == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One-cycle write; the #1 lets the taking edge land first
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input bit byDma = 0,
    input logic [3:0] ch = 4'h0);
    @(posedge mclk);
    regAddr <= a;
    regWrData <= d;
    dmaWr <= byDma;
    dmaWrCh <= ch;
    regWr <= 1'b1;
    @(posedge mclk);
    regWr <= 1'b0;
    dmaWr <= 1'b0;
    #1;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    @(posedge mclk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge mclk);
    regRd <= 1'b0;
    #1;
    chk(nm, e, regRdData);
  endtask

  task automatic start_units(input logic [3:0] ch, input logic [15:0] n, input bit s);
    @(posedge mclk);
    runCh <= ch;
    slow <= s;
    loadCnt <= n;
    load <= 1'b1;
    @(posedge mclk);
    load <= 1'b0;
    #1;
  endtask

  // Bounded wait for channel drop or engine idle
  task automatic wait_done(input int ch, input bit forIdle);
    int n;
    n = 0;
    while ((forIdle ? !idle : chEn[ch]) && n < 2000)
    begin
      @(posedge mclk);
      #1;
      n++;
    end
    if (n >= 2000)
    begin
      errors++;
      $display("BAD wait expected done seen hang");
    end
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset;
    rd(OFF_MASK, 32'h0, "mask");
    rd(OFF_STAT, 32'h0, "stat");
    rd(8'h1C, 32'h0, "cnt1");
    chk("irq", 32'h0, irqTap);
  endtask

  // Normal run of 4 units, then a 256-unit rerun on the leftover count
  task automatic t_normal;
    wr(8'h1C, 32'h3);
    wr(8'h14, 32'h100);
    wr(8'h18, 32'h200);
    start_units(4'h1, 16'h03E8, 1'b0);
    wr(8'h10, 32'h21);
    wait_done(1, 1'b0);
    rd(8'h1C, 32'hFF, "cnt1");
    rd(8'h14, 32'h100, "src1");
    rd(8'h18, 32'h204, "dst1");
    rd(8'h10, 32'h20, "ctl1");
    rd(OFF_STAT, 32'h2, "stat");
    chk("irq", 32'h1, irqTap);
    wr(OFF_STAT, 32'hFFFFFFFD);
    wr(8'h10, 32'h31);
    wait_done(1, 1'b0);
    rd(8'h18, 32'h304, "dst1");
    rd(8'h14, 32'h200, "src1");
    wr(OFF_STAT, 32'hFFFFFFFD);
  endtask

  // Masked completion, 16-bit units, slow engine, write-one-keeps
  task automatic t_mask;
    wr(OFF_MASK, 32'h4);
    wr(8'h2C, 32'h0);
    wr(8'h28, 32'h300);
    start_units(4'h2, 16'h0005, 1'b1);
    wr(8'h20, 32'h29);
    wait_done(2, 1'b0);
    rd(8'h28, 32'h302, "dst2");
    rd(OFF_STAT, 32'h4, "stat");
    chk("irq", 32'h0, irqTap);
    wr(OFF_MASK, 32'h0);
    chk("irq", 32'h1, irqTap);
    wr(OFF_STAT, 32'hFFFFFFFF);
    rd(OFF_STAT, 32'h4, "stat");
    wr(OFF_STAT, 32'hFFFFFFFB);
    chk("irq", 32'h0, irqTap);
  endtask

  // Ring run of 40 units through count zero, stopped by software
  task automatic t_ring;
    wr(8'h3C, 32'h1);
    wr(8'h38, 32'h400);
    start_units(4'h3, 16'h0028, 1'b0);
    wr(8'h30, 32'h25);
    wait_done(3, 1'b1);
    chk("en3", 32'h1, chEn[3]);
    rd(8'h3C, 32'hD9, "cnt3");
    rd(8'h38, 32'h408, "dst3");
    wr(8'h30, 32'h24);
    chk("en3", 32'h0, chEn[3]);
    rd(OFF_STAT, 32'h0, "stat");
    chk("irq", 32'h0, irqTap);
  endtask

  // Protection of an enabled channel and the request flag
  task automatic t_cross;
    wr(8'h4C, 32'h7);
    wr(8'h40, 32'h1);
    wr(8'h4C, 32'h33);
    rd(8'h4C, 32'h7, "cnt4");
    wr(8'h44, 32'h1234, 1'b1, 4'h0);
    rd(8'h44, 32'h1234, "src4");
    wr(8'h48, 32'h99, 1'b1, 4'h4);
    rd(8'h48, 32'h0, "dst4");
    wr(8'h40, 32'h3);
    chk("req4", 32'h0, chReq[4]);
    @(posedge mclk);
    dmaReq <= 10'h010;
    @(posedge mclk);
    dmaReq <= 10'h000;
    #1;
    chk("req4", 32'h1, chReq[4]);
    wr(8'h40, 32'h1);
    chk("req4", 32'h0, chReq[4]);
    wr(8'h40, 32'h0);
    chk("en4", 32'h0, chEn[4]);
  endtask

  // ****************************************
  // Main sequence and watchdog
  // ****************************************
  initial
  begin
    mclk = 1'b0;
    rst_b = 1'b0;
    {regWr, regRd, dmaWr, slow, load} = 5'h00;
    regAddr = 8'h00;
    regWrData = 32'h0;
    {dmaWrCh, runCh} = 8'h00;
    dmaReq = 10'h000;
    loadCnt = 16'h0000;
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    t_reset;
    t_normal;
    t_mask;
    t_ring;
    t_cross;
    close_out;
  end

  // Whole run needs under 2000 cycles; ten times that is a hang
  initial
  begin
    #(50 * 20000);
    errors++;
    close_out;
  end
endmodule
